//--- src/odtc_pkg.sv
package odtc_pkg;
  // Notes on behaviour
  // RULE1: termination follows ODT when enabled; with mode bits disabling it, stays off.
  // RULE2: termination enabled when nominal or write termination field is non-zero.
  // RULE3: ODT ignored while mode fields disable it, and throughout self-refresh.
  // RULE4: on/off decision uses only ODT and mode bits, never command decode; code also gates on DLL sync and refresh-decoded self-refresh.
  // RULE5: synchronous timing whenever the DLL is on and locked.
  // RULE6: DLL off in slow-exit precharge power-down; on in fast-exit and active.
  // RULE7: controller keeps termination disabled while the DLL is off.
  // RULE8: termination switches a fixed latency after ODT sampled high or low.
  // RULE9: that latency is write latency plus additive latency minus two.
  // RULE10: controller keeps ODT high four cycles after first registered high.
  // RULE11: after a write with ODT high, ODT stays high four or six cycles.
  // RULE12: ODT may fall only after the later of both minimum high times.
  // RULE13: minimum high time is 4 cycles, or 6 after a burst-of-eight write.
  // RULE14: controller drops ODT around reads, preamble to postamble.
  // RULE15: termination covers each data-group pin, TDQS when enabled, both x16 lanes.
  // RULE16: controller blocks ODT deassertion until its high-time counters expire.
  localparam int unsigned ODTH4_CYC   = 4;
  localparam int unsigned ODTH8_CYC   = 6;
  localparam int unsigned ODT_LAT_SUB = 2;
  localparam int unsigned DLY_EXTRA   = 3;

  localparam logic [3:0] ADDR_CFG  = 4'h0;
  localparam logic [3:0] ADDR_LAT  = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;

  localparam int unsigned CFG_NOM_LSB  = 0;
  localparam int unsigned CFG_WR_LSB   = 3;
  localparam int unsigned CFG_DLLPD    = 5;
  localparam int unsigned CFG_TDQS     = 6;
  localparam int unsigned CFG_WID_LSB  = 8;
  localparam int unsigned LAT_CWL_LSB  = 0;
  localparam int unsigned LAT_AL_LSB   = 8;
  localparam int unsigned STAT_VIOL    = 8;

  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] LAT_RST = 16'h0005;

  typedef enum logic [1:0] {
    WID_X4  = 2'h0,
    WID_X8  = 2'h1,
    WID_X16 = 2'h2
  } odtc_width_type;

  typedef enum logic [1:0] {
    PWR_ACT  = 2'h0,
    PWR_PDF  = 2'h1,
    PWR_PDS  = 2'h3,
    PWR_SREF = 2'h2
  } odtc_pwr_type;
endpackage : odtc_pkg

//--- src/odtc_xfer.sv
`timescale 1ns/100ps
module odtc_xfer #(
  parameter int          WIDTH = 32,
  parameter logic [31:0] RST   = 32'h0
) (
  input  wire logic             clk_a,
  input  wire logic             rst_a,
  input  wire logic             send,
  input  wire logic [WIDTH-1:0] din,
  output logic                  busy,
  input  wire logic             clk_b,
  input  wire logic             rst_b,
  output logic [WIDTH-1:0]      dout_q
);
  if (WIDTH < 1 || WIDTH > 32) $error("odtc_xfer width out of range");

  logic             req_t_q;
  logic [WIDTH-1:0] data_q;
  logic             ack_m_q;
  logic             ack_s_q;
  logic             req_m_q;
  logic             req_s_q;
  logic             req_p_q;

  // data is held until the toggle has come back, so the far side samples it stable
  always_ff @(posedge clk_a) begin
    if (rst_a) begin
      req_t_q <= 1'b0;
      data_q  <= RST[WIDTH-1:0];
    end else if (send) begin
      req_t_q <= ~req_t_q;
      data_q  <= din;
    end
  end

  always_ff @(posedge clk_a) begin
    if (rst_a) begin
      ack_m_q <= 1'b0;
      ack_s_q <= 1'b0;
    end else begin
      ack_m_q <= req_p_q;
      ack_s_q <= ack_m_q;
    end
  end

  assign busy = req_t_q ^ ack_s_q;

  always_ff @(posedge clk_b) begin
    if (rst_b) begin
      req_m_q <= 1'b0;
      req_s_q <= 1'b0;
      req_p_q <= 1'b0;
    end else begin
      req_m_q <= req_t_q;
      req_s_q <= req_m_q;
      req_p_q <= req_s_q;
    end
  end

  always_ff @(posedge clk_b) begin
    if (rst_b) begin
      dout_q <= RST[WIDTH-1:0];
    end else if (req_s_q ^ req_p_q) begin
      dout_q <= data_q;
    end
  end
endmodule : odtc_xfer

//--- src/odtc_dly.sv
`timescale 1ns/100ps
module odtc_dly #(
  parameter  int DEPTH = 32,
  localparam int TW    = $clog2(DEPTH)
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          din,
  input  wire logic [TW-1:0] tap,
  output logic               dout_q
);
  if (DEPTH < 2 || DEPTH > 64) $error("odtc_dly depth out of range");

  logic [DEPTH-1:0] sr_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      sr_q <= '0;
    end else begin
      sr_q <= {sr_q[DEPTH-2:0], din};
    end
  end

  // tap k gives din back k+2 edges later
  always_ff @(posedge clk) begin
    if (rst) begin
      dout_q <= 1'b0;
    end else begin
      dout_q <= sr_q[tap];
    end
  end
endmodule : odtc_dly

//--- src/odtc_top.sv
`timescale 1ns/100ps
module odtc_top
  import odtc_pkg::*;
#(
  parameter int LAT_DEPTH = 32
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        link_clk,
  input  wire logic        odt,
  input  wire logic        cke,
  input  wire logic        cmd_write,
  input  wire logic        cmd_bc4,
  input  wire logic        cmd_refresh,
  input  wire logic        bank_open,
  input  wire logic        dll_locked,
  output logic             dll_enable,
  output logic [1:0]       term_dq,
  output logic             term_tdqs
);
  localparam int TW = $clog2(LAT_DEPTH);
  localparam logic [2:0] H4_LD = 3'(ODTH4_CYC - 1);
  localparam logic [2:0] H8_LD = 3'(ODTH8_CYC - 1);

  if (LAT_DEPTH < 4 || LAT_DEPTH > 64) $error("LAT_DEPTH out of range");

  typedef enum logic [1:0] {
    SEL_CFG  = 2'h0,
    SEL_LAT  = 2'h1,
    SEL_STAT = 2'h2,
    SEL_NONE = 2'h3
  } odtc_sel_type;

  function automatic odtc_sel_type reg_sel(input logic [3:0] a);
    unique case (a)
      ADDR_CFG:  reg_sel = SEL_CFG;
      ADDR_LAT:  reg_sel = SEL_LAT;
      ADDR_STAT: reg_sel = SEL_STAT;
      default:   reg_sel = SEL_NONE;
    endcase
  endfunction : reg_sel

  function automatic logic [15:0] bmerge(input logic [15:0] old,
                                         input logic [15:0] wd,
                                         input logic [1:0]  be);
    bmerge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : bmerge

  // ---------------- register side (clock) ----------------
  odtc_sel_type sel;
  logic         req;
  logic         stall;
  logic         accept;
  logic         done_q;
  logic [15:0]  cfg_q;
  logic [15:0]  lat_q;
  logic [15:0]  cfg_d;
  logic [15:0]  lat_d;
  logic         hs_send;
  logic         hs_busy;
  logic [5:0]   stat_m_q;
  logic [5:0]   stat_s_q;
  logic         viol_p_q;
  logic         viol_q;
  logic         viol_set;
  logic [5:0]   stat_l;

  assign sel   = reg_sel(avs_address);
  assign req   = avs_read | avs_write;
  // a new mode setting waits until the previous one has reached the link side
  assign stall = avs_write && (sel == SEL_CFG || sel == SEL_LAT) && hs_busy;
  assign avs_waitrequest = req && !done_q;
  assign accept  = req && done_q;
  assign cfg_d   = (sel == SEL_CFG) ? bmerge(cfg_q, avs_writedata[15:0],
                                             avs_byteenable[1:0]) : cfg_q;
  assign lat_d   = (sel == SEL_LAT) ? bmerge(lat_q, avs_writedata[15:0],
                                             avs_byteenable[1:0]) : lat_q;
  assign hs_send = accept && avs_write && (sel == SEL_CFG || sel == SEL_LAT);

  always_ff @(posedge clock) begin
    if (srst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= req && !done_q && !stall;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_q <= CFG_RST;
      lat_q <= LAT_RST;
    end else if (hs_send) begin
      cfg_q <= cfg_d;
      lat_q <= lat_d;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      avs_readdata <= 32'h0;
    end else if (req && !done_q) begin
      unique case (sel)
        SEL_CFG:  avs_readdata <= {16'h0, cfg_q};
        SEL_LAT:  avs_readdata <= {16'h0, lat_q};
        SEL_STAT: avs_readdata <= {23'h0, viol_q, 3'h0, stat_s_q[4:0]};
        SEL_NONE: avs_readdata <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      stat_m_q <= 6'h0;
      stat_s_q <= 6'h0;
      viol_p_q <= 1'b0;
    end else begin
      stat_m_q <= stat_l;
      stat_s_q <= stat_m_q;
      viol_p_q <= stat_s_q[5];
    end
  end

  assign viol_set = stat_s_q[5] ^ viol_p_q;

  // write one to clear; a violation in the same cycle wins
  always_ff @(posedge clock) begin
    if (srst) begin
      viol_q <= 1'b0;
    end else if (viol_set) begin
      viol_q <= 1'b1;
    end else if (accept && avs_write && sel == SEL_STAT && avs_byteenable[1]
                 && avs_writedata[STAT_VIOL]) begin
      viol_q <= 1'b0;
    end
  end

  // ---------------- link side (link_clk) ----------------
  logic         lrst_m_q;
  logic         lrst_q;
  logic [31:0]  cfg_l;
  logic         odt_q;
  logic         odt_p_q;
  logic         cke_q;
  logic         wr_q;
  logic         bc4_q;
  logic         ref_q;
  logic         bank_q;
  logic         lock_m_q;
  logic         lock_s_q;
  odtc_pwr_type pwr_q;
  logic         dll_en_q;
  logic         sync_q;
  logic [5:0]   lat_l_q;
  logic [TW-1:0] tap_q;
  logic         dly_out;
  logic         term_en;
  logic         gate;
  logic         term_q;
  logic [1:0]   lane_q;
  logic         tdqs_q;
  logic [2:0]   hold_q;
  logic [2:0]   hold_dec;
  logic [2:0]   hold_wr;
  logic [2:0]   hold_rise;
  logic         odt_rise;
  logic         odt_fall;
  logic         viol_t_q;
  logic [6:0]   lat_sum;
  odtc_width_type wid;

  always_ff @(posedge link_clk) begin
    lrst_m_q <= srst;
    lrst_q   <= lrst_m_q;
  end

  odtc_xfer #(
    .WIDTH (32),
    .RST   ({LAT_RST, CFG_RST})
  ) u_xfer (
    .clk_a  (clock),
    .rst_a  (srst),
    .send   (hs_send),
    .din    ({lat_d, cfg_d}),
    .busy   (hs_busy),
    .clk_b  (link_clk),
    .rst_b  (lrst_q),
    .dout_q (cfg_l)
  );

  // ODT and commands are registered on the rising link edge
  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      odt_q   <= 1'b0;
      odt_p_q <= 1'b0;
      cke_q   <= 1'b1;
      wr_q    <= 1'b0;
      bc4_q   <= 1'b0;
      ref_q   <= 1'b0;
      bank_q  <= 1'b0;
    end else begin
      odt_q   <= odt;
      odt_p_q <= odt_q;
      cke_q   <= cke;
      wr_q    <= cmd_write;
      bc4_q   <= cmd_bc4;
      ref_q   <= cmd_refresh;
      bank_q  <= bank_open;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      lock_m_q <= 1'b0;
      lock_s_q <= 1'b0;
    end else begin
      lock_m_q <= dll_locked;
      lock_s_q <= lock_m_q;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      pwr_q <= PWR_ACT;
    end else begin
      unique case (pwr_q)
        PWR_ACT: begin
          if (!cke_q) begin
            if (ref_q) begin
              pwr_q <= PWR_SREF;
            end else if (bank_q || cfg_l[CFG_DLLPD]) begin
              pwr_q <= PWR_PDF; // RULE6
            end else begin
              pwr_q <= PWR_PDS; // RULE6
            end
          end
        end
        PWR_PDF, PWR_PDS, PWR_SREF: begin
          if (cke_q) begin
            pwr_q <= PWR_ACT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      dll_en_q <= 1'b1;
    end else begin
      dll_en_q <= (pwr_q != PWR_PDS) && (pwr_q != PWR_SREF); // RULE6
    end
  end

  assign dll_enable = dll_en_q;

  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= dll_en_q && lock_s_q; // RULE5
    end
  end

  assign lat_sum = 7'(cfg_l[16+LAT_CWL_LSB +: 5]) + 7'(cfg_l[16+LAT_AL_LSB +: 5])
                   - 7'(ODT_LAT_SUB); // RULE9

  // latencies beyond the line are clipped; below three the line cannot go
  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      lat_l_q <= 6'h3;
      tap_q   <= '0;
    end else begin
      lat_l_q <= lat_sum[5:0];
      // a sum below the subtraction wraps into bit 6; it clips to the minimum too
      if (lat_sum < 7'(DLY_EXTRA) || lat_sum[6]) begin
        tap_q <= '0;
      end else if (lat_sum - 7'(DLY_EXTRA) > 7'(LAT_DEPTH - 1)) begin
        tap_q <= TW'(LAT_DEPTH - 1);
      end else begin
        tap_q <= TW'(lat_sum - 7'(DLY_EXTRA));
      end
    end
  end

  odtc_dly #(
    .DEPTH (LAT_DEPTH)
  ) u_dly (
    .clk    (link_clk),
    .rst    (lrst_q),
    .din    (odt_q),
    .tap    (tap_q),
    .dout_q (dly_out)
  );

  assign term_en = (cfg_l[CFG_NOM_LSB +: 3] != 3'h0)
                || (cfg_l[CFG_WR_LSB +: 2] != 2'h0); // RULE2
  assign gate    = term_en && sync_q && (pwr_q != PWR_SREF); // RULE3 RULE5
  assign wid     = odtc_width_type'(cfg_l[CFG_WID_LSB +: 2]);

  // the delayed pin, mode bits, DLL sync and self-refresh state decide; write commands stay out
  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      term_q <= 1'b0;
      lane_q <= 2'h0;
      tdqs_q <= 1'b0;
    end else begin
      term_q    <= dly_out && gate; // RULE1 RULE4 RULE8
      lane_q[0] <= dly_out && gate; // RULE15
      lane_q[1] <= dly_out && gate && (wid == WID_X16); // RULE15
      tdqs_q    <= dly_out && gate && (wid == WID_X8) && cfg_l[CFG_TDQS]; // RULE15
    end
  end

  assign term_dq   = lane_q;
  assign term_tdqs = tdqs_q;

  // minimum ODT high time watch on the partner, longest of both claims
  assign odt_rise  = odt_q && !odt_p_q;
  assign odt_fall  = !odt_q && odt_p_q;
  assign hold_dec  = (hold_q == 3'h0) ? 3'h0 : hold_q - 3'h1;
  assign hold_wr   = (wr_q && odt_q) ? (bc4_q ? H4_LD : H8_LD) : 3'h0; // RULE11 RULE13
  assign hold_rise = odt_rise ? H4_LD : 3'h0; // RULE10 RULE13

  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      hold_q <= 3'h0;
    end else if (!odt_q) begin
      hold_q <= 3'h0;
    end else if (hold_wr >= hold_dec && hold_wr >= hold_rise) begin
      hold_q <= hold_wr; // RULE12
    end else if (hold_rise >= hold_dec) begin
      hold_q <= hold_rise;
    end else begin
      hold_q <= hold_dec;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      viol_t_q <= 1'b0;
    end else if (odt_fall && hold_q != 3'h0) begin
      viol_t_q <= ~viol_t_q; // RULE12 RULE16
    end
  end

  assign stat_l = {viol_t_q, pwr_q, dll_en_q, sync_q, term_q};

  // ---------------- checks ----------------
  a_bus_answer: assert property (@(posedge clock) disable iff (srst)
    req && !done_q && !stall |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");

  a_sref_off: assert property (@(posedge link_clk) disable iff (lrst_q) // RULE3
    pwr_q == PWR_SREF |=> !term_q)
    else $error("termination on during self-refresh");

  a_mode_off: assert property (@(posedge link_clk) disable iff (lrst_q) // RULE1
    !term_en && $past(!term_en) |-> !term_q && term_dq == 2'h0)
    else $error("termination on while disabled by mode bits");

  a_dll_off_slow: assert property (@(posedge link_clk) disable iff (lrst_q) // RULE6
    pwr_q == PWR_PDS ##1 pwr_q == PWR_PDS |-> !dll_enable)
    else $error("DLL left on in slow-exit power-down");

  a_dll_on_fast: assert property (@(posedge link_clk) disable iff (lrst_q) // RULE6
    pwr_q == PWR_PDF ##1 pwr_q == PWR_PDF |-> dll_enable)
    else $error("DLL off in fast-exit power-down");

  a_sync_gate: assert property (@(posedge link_clk) disable iff (lrst_q) // RULE5
    !sync_q |=> !term_q)
    else $error("termination on without locked DLL");

  a_turn_latency: assert property (@(posedge link_clk) disable iff (lrst_q) // RULE8
    lat_l_q == 6'd3 && $past(lat_l_q, 3) == 6'd3 && $past(gate)
    |-> term_q == $past(odt_q, 3))
    else $error("termination does not follow ODT after latency");

  a_odth_bl8: assert property (@(posedge link_clk) disable iff (lrst_q) // RULE13
    wr_q && odt_q && !bc4_q |=> odt_q |-> hold_q >= 3'd5)
    else $error("burst-of-eight hold not loaded");

  a_odth_first: assert property (@(posedge link_clk) disable iff (lrst_q) // RULE10
    odt_rise ##1 odt_q |-> hold_q >= 3'd3)
    else $error("first-high hold not loaded");

  a_odth_short: assert property (@(posedge link_clk) disable iff (lrst_q) // RULE12
    odt_fall && hold_q != 3'h0 |=> viol_t_q != $past(viol_t_q))
    else $error("short ODT pulse not flagged");

  a_x16_lane: assert property (@(posedge link_clk) disable iff (lrst_q) // RULE15
    $past(wid != WID_X16) |-> !term_dq[1])
    else $error("upper lane terminated outside x16");

  c_term_on: cover property (@(posedge link_clk) disable iff (lrst_q) $rose(term_q));
  c_odth_viol: cover property (@(posedge link_clk) disable iff (lrst_q)
    odt_fall && hold_q != 3'h0);
  c_sref: cover property (@(posedge link_clk) disable iff (lrst_q)
    pwr_q == PWR_SREF);
  c_wr_bl8: cover property (@(posedge link_clk) disable iff (lrst_q)
    wr_q && odt_q && !bc4_q);
endmodule : odtc_top

//--- verif/odtc_ctrl_model.sv
`timescale 1ns/100ps
module odtc_ctrl_model
  import odtc_pkg::*;
(
  input  wire logic link_clk,
  input  wire logic rst,
  input  wire logic want_odt,
  input  wire logic want_low,
  input  wire logic wr_tgl,
  input  wire logic wr_bc4,
  input  wire logic pd_req,
  input  wire logic sr_req,
  input  wire logic open_bank,
  input  wire logic break_rule,
  output logic      odt,
  output logic      cke,
  output logic      cmd_write,
  output logic      cmd_bc4,
  output logic      cmd_refresh,
  output logic      bank_open
);
  int   hold_q;
  logic wr_seen_q;

  // hold_q: edges still to pass before odt may be registered low
  always @(posedge link_clk) begin : ctrl
    int   c;
    logic wr_go;
    c = (hold_q > 0) ? hold_q - 1 : 0;
    // writes only go out with odt high and staying high
    wr_go = !rst && (wr_tgl != wr_seen_q) && odt && cke && !break_rule;
    if (wr_go) begin
      c = (c > (wr_bc4 ? ODTH4_CYC : ODTH8_CYC)) ? c : (wr_bc4 ? ODTH4_CYC : ODTH8_CYC);
    end
    if (rst) begin
      odt <= 1'b0;
      c = 0;
    end else if (!odt && want_odt && !want_low) begin
      odt <= 1'b1;
      c = ODTH4_CYC;
    end else if (odt && (break_rule || ((!want_odt || want_low) && c == 0))) begin
      odt <= 1'b0;
    end
    hold_q      <= c;
    wr_seen_q   <= wr_tgl;
    cmd_write   <= wr_go;
    // between writes the burst bit carries bit 0 of the hold count
    cmd_bc4     <= wr_go ? wr_bc4 : c[0];
    cke         <= rst || !(pd_req || sr_req);
    cmd_refresh <= !rst && sr_req && cke;
    bank_open   <= open_bank;
  end
endmodule : odtc_ctrl_model

//--- verif/odtc_top_tb.sv
`timescale 1ns/100ps
module odtc_top_tb;
  import odtc_pkg::*;
  localparam int LAT_DEPTH = 32;
  localparam int MAX_CYC   = 10000;
  localparam logic [4:0] EN_TAB [4] = '{5'h00, 5'h04, 5'h08, 5'h10};
  localparam logic [1:0] WID_TAB [4] = '{WID_X4, WID_X8, WID_X8, WID_X16};
  localparam odtc_pwr_type PW_TAB [4] = '{PWR_PDF, PWR_PDF, PWR_PDS, PWR_SREF};
  logic        clock, srst, link_clk, dll_locked, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        odt, cke, cmd_write, cmd_bc4, cmd_refresh, bank_open, dll_enable, term_tdqs;
  logic [1:0]  term_dq, cur_wid;
  logic        want_odt, want_low, wr_tgl, wr_bc4, pd_req, sr_req, open_bank, break_rule;
  logic        cur_en, cur_tdqs;
  logic [39:0] hist;
  int          error_cnt, n_compared, seed, chk, cur_lat, cyc;

  always #10 clock = ~clock;
  always #3 link_clk = ~link_clk;

  odtc_top #(.LAT_DEPTH(LAT_DEPTH)) i_odtc_top (
    .clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link_clk(link_clk),
    .odt(odt), .cke(cke), .cmd_write(cmd_write), .cmd_bc4(cmd_bc4),
    .cmd_refresh(cmd_refresh), .bank_open(bank_open), .dll_locked(dll_locked),
    .dll_enable(dll_enable), .term_dq(term_dq), .term_tdqs(term_tdqs));

  odtc_ctrl_model i_odtc_ctrl_model (
    .link_clk(link_clk), .rst(srst), .want_odt(want_odt), .want_low(want_low),
    .wr_tgl(wr_tgl), .wr_bc4(wr_bc4), .pd_req(pd_req), .sr_req(sr_req),
    .open_bank(open_bank), .break_rule(break_rule), .odt(odt), .cke(cke),
    .cmd_write(cmd_write), .cmd_bc4(cmd_bc4), .cmd_refresh(cmd_refresh),
    .bank_open(bank_open));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  // request held until the edge that samples waitrequest low
  task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                          input logic [3:0] be, output logic [31:0] d);
    int n;
    avs_address    <= a;
    avs_writedata  <= wd;
    avs_byteenable <= be;
    avs_read       <= !wr;
    avs_write      <= wr;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 200);
    d = avs_readdata;
    if (n >= 200) begin
      check(32'h0, 32'h1, "bus answer");
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask : bus_xfer

  function automatic int lat_of(input int cwl, input int al);
    int l;
    l = cwl + al - ODT_LAT_SUB;
    l = (l < 3) ? 3 : l;
    return (l > LAT_DEPTH + 2) ? LAT_DEPTH + 2 : l;
  endfunction : lat_of

  function automatic logic [31:0] exp_term(input logic on);
    logic t;
    t = on & cur_en;
    return {29'h0, t & (cur_wid == WID_X8) & cur_tdqs, t & (cur_wid == WID_X16), t};
  endfunction : exp_term

  task automatic setup(input logic [6:0] lo, input logic [1:0] wid, input int cwl,
                       input int al);
    chk = 0;
    want_odt <= 1'b0;
    repeat (20) @(posedge clock);
    bus_xfer(1'b1, ADDR_CFG, {22'h0, wid, 1'b0, lo}, 4'hf, rd);
    bus_xfer(1'b1, ADDR_LAT, {19'h0, 5'(al), 3'h0, 5'(cwl)}, 4'hf, rd);
    cur_lat  = lat_of(cwl, al);
    cur_en   = |lo[4:0];
    cur_tdqs = lo[CFG_TDQS];
    cur_wid  = wid;
    // let config cross and the delay line flush
    repeat (30) @(posedge clock);
  endtask : setup

  task automatic traffic(input int n);
    repeat (n) begin
      @(posedge clock);
      if ($random(seed) % 4 == 0) begin
        want_odt <= ~want_odt;
      end
      if ($random(seed) % 5 == 0) begin
        wr_tgl <= ~wr_tgl;
        wr_bc4 <= 1'($random(seed));
      end
    end
  endtask : traffic

  always @(posedge link_clk) begin
    if (chk == 1) begin
      check({29'h0, term_tdqs, term_dq}, exp_term(hist[cur_lat]), "term follow");
    end
    if (chk == 2) begin
      check({29'h0, term_tdqs, term_dq}, 32'h0, "term forced off");
    end
    hist = {hist[38:0], odt};
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == MAX_CYC) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    seed = 4;
    {clock, link_clk, chk, cyc, error_cnt, n_compared, hist} = '0;
    {srst, dll_locked} = 2'h3;
    {avs_address, avs_writedata, avs_byteenable, avs_read, avs_write} = '0;
    {want_odt, want_low, wr_tgl, wr_bc4, pd_req, sr_req, open_bank, break_rule} = '0;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    bus_xfer(1'b0, ADDR_CFG, 32'h0, 4'hf, rd);
    check(rd, {16'h0, CFG_RST}, "cfg reset");
    bus_xfer(1'b0, ADDR_LAT, 32'h0, 4'hf, rd);
    check(rd, {16'h0, LAT_RST}, "lat reset");
    bus_xfer(1'b1, 4'hc, 32'hffff_ffff, 4'hf, rd);
    bus_xfer(1'b0, 4'hc, 32'h0, 4'hf, rd);
    check(rd, 32'h0, "unmapped read");
    bus_xfer(1'b1, ADDR_LAT, 32'h0000_0707, 4'h1, rd);
    bus_xfer(1'b0, ADDR_LAT, 32'h0, 4'hf, rd);
    check(rd, 32'h0000_0007, "lane write");
    check({31'h0, dll_enable}, 32'h1, "dll after reset");
    $display("done: registers");
    for (int i = 0; i < 4; i++) begin
      setup({2'b00, EN_TAB[i]}, WID_X4, 5, 0);
      chk = 1;
      traffic(80);
    end
    $display("done: enable fields");
    for (int i = 0; i < 8; i++) begin
      setup({i % 4 == 1, 6'h01}, WID_TAB[i % 4], 5 + ($unsigned($random(seed)) % 8),
            $unsigned($random(seed)) % 9);
      chk = 1;
      traffic(100);
    end
    bus_xfer(1'b0, ADDR_STAT, 32'h0, 4'hf, rd);
    check(32'(rd[STAT_VIOL]), 32'h0, "no violation");
    $display("done: widths and latencies");
    setup(7'h02, WID_X8, 5, 0);
    break_rule <= 1'b1;
    want_odt   <= 1'b1;
    repeat (10) @(posedge clock);
    break_rule <= 1'b0;
    want_odt   <= 1'b0;
    repeat (10) @(posedge clock);
    bus_xfer(1'b0, ADDR_STAT, 32'h0, 4'hf, rd);
    check(32'(rd[STAT_VIOL]), 32'h1, "violation seen");
    bus_xfer(1'b1, ADDR_STAT, 32'h0000_0100, 4'hf, rd);
    bus_xfer(1'b0, ADDR_STAT, 32'h0, 4'hf, rd);
    check(32'(rd[STAT_VIOL]), 32'h0, "violation cleared");
    $display("done: high time");
    // deliberately odt traffic with the dll unlocked: must be ignored
    setup(7'h02, WID_X4, 6, 1);
    dll_locked <= 1'b0;
    repeat (10) @(posedge clock);
    chk = 2;
    traffic(60);
    bus_xfer(1'b0, ADDR_STAT, 32'h0, 4'hf, rd);
    check(32'(rd[1]), 32'h0, "sync mode off");
    dll_locked <= 1'b1;
    $display("done: dll unlocked");
    for (int i = 0; i < 4; i++) begin
      setup({1'b0, i == 1, 5'h02}, WID_X4, 5, 2);
      want_odt  <= 1'b1;
      want_low  <= (i == 2);
      open_bank <= (i == 0);
      pd_req    <= (i < 3);
      sr_req    <= (i == 3);
      repeat (30) @(posedge clock);
      chk = (i < 2) ? 1 : 2;
      repeat (40) @(posedge clock);
      bus_xfer(1'b0, ADDR_STAT, 32'h0, 4'hf, rd);
      check(32'(rd[4:3]), 32'(PW_TAB[i]), "power state");
      check({30'h0, rd[2], dll_enable}, (i < 2) ? 32'h3 : 32'h0, "dll enable");
      chk = 0;
      want_odt <= 1'b0;
      want_low <= 1'b0;
      pd_req   <= 1'b0;
      sr_req   <= 1'b0;
      repeat (10) @(posedge clock);
    end
    $display("done: power states");
    complete_run();
  end
endmodule : odtc_top_tb
